// ===== common/gio_pkg.sv
// Purpose: Shared constants of the global I/O control register group.
// Assumes: Byte-wide register port, 16-bit byte addresses, 100 MHz system clock.
// Notes:   Multi-byte registers are big-endian: the lowest address holds the top byte.

package gio_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_SYS_MHZ        = 100;
  localparam int unsigned SPI_FAST_CLK_MHZ   = 25;
  // Longest serial clock period, in system cycles, still taken as a fast clock.
  localparam int unsigned SPI_FAST_PERIOD_CYC = CLK_SYS_MHZ / SPI_FAST_CLK_MHZ;
  localparam int unsigned MGMT_PREAMBLE_BITS = 32;
  localparam int unsigned MGMT_FRAME_BITS    = 32;
  localparam int unsigned SYNC_STAGES        = 2;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [15:0] ADDR_SERIAL_IO_CTRL = 16'h0100;
  localparam logic [15:0] ADDR_OUT_CLK_CTRL   = 16'h0103;
  localparam logic [15:0] ADDR_INBAND_CTRL    = 16'h0104;
  localparam logic [15:0] ADDR_INBAND_CTRL_LAST = 16'h0107;
  localparam logic [15:0] ADDR_PAD_DRIVE      = 16'h010D;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned SIO_PREAMBLE_SUPP_BIT = 2;
  localparam int unsigned SIO_AUTO_EDGE_BIT     = 1;
  localparam int unsigned SIO_MANUAL_EDGE_BIT   = 0;
  localparam int unsigned OCK_ENABLE_BIT        = 1;
  localparam int unsigned OCK_FREQ_BIT          = 0;
  localparam int unsigned IBA_ENABLE_BIT        = 31;
  localparam int unsigned IBA_MAC_CHECK_BIT     = 30;
  localparam int unsigned IBA_RESET_BIT         = 29;
  localparam int unsigned IBA_QUEUE_LSB         = 22;
  localparam int unsigned IBA_PORT_LSB          = 16;
  localparam int unsigned IBA_TPID_LSB          = 0;
  localparam int unsigned PAD_HIGH_LSB          = 4;
  localparam int unsigned PAD_LOW_LSB           = 0;

  // ==========================================================================
  // Reset values and writable masks
  // ==========================================================================
  localparam logic [7:0]  SERIAL_IO_RESET = 8'h42;
  localparam logic [7:0]  SERIAL_IO_WMASK = 8'hFF;
  localparam logic [7:0]  OUT_CLK_RESET   = 8'h02;
  localparam logic [7:0]  OUT_CLK_WMASK   = 8'h1F;
  localparam logic [31:0] INBAND_RESET    = 32'h0045_40FE;
  // Bit 29 is not stored: it is a write-one pulse that always reads zero.
  localparam logic [31:0] INBAND_WMASK    = 32'hC0C7_FFFF;
  localparam logic [7:0]  PAD_DRIVE_RESET = 8'h62;
  localparam logic [7:0]  PAD_DRIVE_WMASK = 8'hFF;
  localparam logic [2:0]  PORT_CODE_LAST  = 3'h5;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

endpackage

// ===== core/gio_mgmt_preamble_gate.sv
// Purpose: Finds frame starts on the two-wire management bus and gates them on the preamble.
// Assumes: Bus clock at most a quarter of the system clock; pins are asynchronous.
// Notes:   A start is the bit pair 0 then 1 on rising bus clock edges.

`timescale 1ns/1ps

module gio_mgmt_preamble_gate (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  // Bus pins
  input  wire logic mdcPin,
  input  wire logic mdioPin,
  // Control
  input  wire logic suppressPreamble,
  // Result
  output logic      frameStart
);

  typedef enum logic [1:0] {HUNT, GOT_ZERO, IN_FRAME} gio_pre_state_type;

  typedef struct packed {
    logic [1:0]        mdcSync;
    logic [1:0]        mdioSync;
    logic              mdcPrev;
    logic [5:0]        ones;
    logic              preambleOk;
    logic [5:0]        bitCnt;
    gio_pre_state_type state;
    logic              start;
  } gio_pre_regs_type;

  gio_pre_regs_type r_q;
  gio_pre_regs_type r_d;

  logic mdcRise;
  logic bitVal;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d          = r_q;
    r_d.mdcSync  = {r_q.mdcSync[0], mdcPin};
    r_d.mdioSync = {r_q.mdioSync[0], mdioPin};
    r_d.mdcPrev  = r_q.mdcSync[1];
    r_d.start    = 1'b0;
    mdcRise      = r_q.mdcSync[1] & ~r_q.mdcPrev;
    bitVal       = r_q.mdioSync[1];
    if (mdcRise) begin
      unique case (r_q.state)
        HUNT: begin
          if (bitVal) begin
            if (r_q.ones != 6'(gio_pkg::MGMT_PREAMBLE_BITS)) begin
              r_d.ones = r_q.ones + 6'h01;
            end
          end else begin
            // A missing preamble only blocks the frame when suppression is off.
            r_d.preambleOk = suppressPreamble ||
                             (r_q.ones == 6'(gio_pkg::MGMT_PREAMBLE_BITS));
            r_d.state      = GOT_ZERO;
          end
        end
        GOT_ZERO: begin
          if (bitVal) begin
            r_d.start  = r_q.preambleOk;
            r_d.bitCnt = 6'h02;
            r_d.state  = IN_FRAME;
          end else begin
            r_d.ones  = 6'h00;
            r_d.state = HUNT;
          end
        end
        IN_FRAME: begin
          r_d.bitCnt = r_q.bitCnt + 6'h01;
          if (r_q.bitCnt == 6'(gio_pkg::MGMT_FRAME_BITS - 1)) begin
            r_d.ones  = 6'h00;
            r_d.state = HUNT;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_q <= '0;
    end else if (clkEn) begin
      r_q <= r_d;
    end
  end

  assign frameStart = r_q.start;

endmodule

// ===== core/gio_spi_edge_select.sv
// Purpose: Chooses the serial clock edge that launches SPI read data.
// Assumes: Serial clock pin is asynchronous to the system clock.
// Notes:   Detection resolves periods of two system cycles or more.

`timescale 1ns/1ps

module gio_spi_edge_select #(
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  // Serial clock pin
  input  wire logic spiClkPin,
  // Control
  input  wire logic autoEdge,
  input  wire logic manualEdgeRising,
  // Result
  output logic      launchRising
);

  typedef struct packed {
    logic [1:0]       sclkSync;
    logic             sclkPrev;
    logic [CNT_W-1:0] period;
    logic             fast;
    logic             rising;
  } gio_edge_regs_type;

  gio_edge_regs_type r_q;
  gio_edge_regs_type r_d;

  logic sclkRise;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d          = r_q;
    r_d.sclkSync = {r_q.sclkSync[0], spiClkPin};
    r_d.sclkPrev = r_q.sclkSync[1];
    sclkRise     = r_q.sclkSync[1] & ~r_q.sclkPrev;
    if (sclkRise) begin
      // Period measured in system cycles between two rising edges.
      r_d.fast   = (r_q.period < CNT_W'(gio_pkg::SPI_FAST_PERIOD_CYC));
      r_d.period = '0;
    end else if (r_q.period != '1) begin
      r_d.period = r_q.period + CNT_W'(1);
    end else begin
      r_d.fast = 1'b0;
    end
    // The manual bit is looked at only with automatic selection off.
    r_d.rising = autoEdge ? r_d.fast : manualEdgeRising;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_q <= '0;
    end else if (clkEn) begin
      r_q <= r_d;
    end
  end

  assign launchRising = r_q.rising;

endmodule

// ===== core/gio_global_io_ctrl.sv
// Purpose: Global I/O control registers of a multi-port switch and the logic they steer.
// Assumes: One byte register port shared by the SPI, I2C and two-wire bus front ends.
// Notes:   Read data is registered one cycle after the read strobe.

`timescale 1ns/1ps

// Function
// - Preamble suppression clear: two-wire bus needs a full preamble before commands.
// - Preamble suppression set: two-wire bus commands accepted without any preamble.
// - Preamble suppression has no effect on SPI or I2C register accesses.
// - Automatic edge: launch SPI data on rising edge at 25 MHz and up.
// - Manual edge mode: bit 0 clear picks falling edge, bit 0 set picks rising edge.
// - With automatic edge on, the reset state, the manual edge bit is ignored.
// - Reference clock pin driven only when enabled; frequency bit picks 25 or 125 MHz.
// - In-band enable resets from the port-6 receive-valid strap; software may change it.
// - MAC check on: frames whose destination differs from switch MAC are discarded.
// - MAC check off: in-band frames accepted without looking at destination.
// - Writing 1 to in-band reset restarts its state machine; bit clears itself.
// - In-band responses go to the two-bit priority queue field, reset 01.
// - Three-bit port field: codes 0-5 are ports 1-6, 6 and 7 reserved, reset 5.
// - Sixteen-bit field holds the in-band frame TPID, reset 0x40FE.
module gio_global_io_ctrl #(
  parameter int unsigned MAC_W = 48
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clkEn,
  // Register port
  input  wire logic [15:0]       regAddr,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire logic [7:0]        regWrData,
  output logic      [7:0]        regRdData,
  // Two-wire management bus pins
  input  wire logic              mdcPin,
  input  wire logic              mdioPin,
  output logic                   mgmtFrameStart,
  // SPI serial clock pin and data-out edge
  input  wire logic              spiClkPin,
  output logic                   sdoLaunchRising,
  // Reference clock output pin control
  output logic                   refClockOutEn,
  output logic                   refClockSel125,
  // Configuration strap
  input  wire logic              port6RxValidStrapPin,
  // In-band management frame header
  input  wire logic              ibaFrameValid,
  input  wire logic [MAC_W-1:0]  ibaFrameDstMac,
  input  wire logic [15:0]       ibaFrameTpid,
  input  wire logic [2:0]        ibaFramePort,
  input  wire logic [MAC_W-1:0]  switchMac,
  // In-band management control and results
  output logic                   ibaFrameAccept,
  output logic                   ibaFrameDiscard,
  output logic                   ibaMacMismatch,
  output logic                   ibaEngineReset,
  output logic                   ibaEnable,
  output logic      [1:0]        ibaRespQueue,
  output logic      [2:0]        ibaPortSel,
  output logic      [15:0]       ibaTpid,
  // Pad drive strength
  output logic      [2:0]        padHighDrive,
  output logic      [2:0]        padLowDrive
);

  typedef struct packed {
    logic [7:0]  serialIo;
    logic [7:0]  outClk;
    logic [31:0] inband;
    logic [7:0]  padDrive;
    logic [1:0]  strapSync;
    logic [1:0]  strapCnt;
    logic        strapDone;
    logic [7:0]  rdData;
    logic        ibaRst;
    logic        accept;
    logic        discard;
    logic        mismatch;
  } gio_top_state_type;

  gio_top_state_type r_q;
  gio_top_state_type r_d;

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Keeps the bits outside the writable mask at their stored values.
  function automatic logic [7:0] gio_merge(
    input logic [7:0] oldVal,
    input logic [7:0] newVal,
    input logic [7:0] wmask
  );
    gio_merge = (oldVal & ~wmask) | (newVal & wmask);
  endfunction

  // Byte lane of the big-endian in-band register for an address inside it.
  function automatic logic [1:0] gio_lane(input logic [15:0] addr);
    logic [15:0] offs;
    offs     = addr - gio_pkg::ADDR_INBAND_CTRL;
    gio_lane = 2'h3 - offs[1:0];
  endfunction

  function automatic logic gio_in_inband(input logic [15:0] addr);
    gio_in_inband = (addr >= gio_pkg::ADDR_INBAND_CTRL) &&
                    (addr <= gio_pkg::ADDR_INBAND_CTRL_LAST);
  endfunction

  logic [1:0]  wrLane;
  logic [1:0]  rdLane;
  logic        portValid;
  logic        macOk;
  logic        tpidOk;
  logic        portOk;
  logic        preambleSupp;
  logic        frameStartRaw;
  logic        launchRisingRaw;

  // ==========================================================================
  // Submodules
  // ==========================================================================
  assign preambleSupp = r_q.serialIo[gio_pkg::SIO_PREAMBLE_SUPP_BIT];

  // Only the two-wire bus front end sees the suppression bit.
  gio_mgmt_preamble_gate u_preamble (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .clkEn            (clkEn),
    .mdcPin           (mdcPin),
    .mdioPin          (mdioPin),
    .suppressPreamble (preambleSupp),
    .frameStart       (frameStartRaw)
  );

  gio_spi_edge_select #(
    .CNT_W (4)
  ) u_spi_edge (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .clkEn            (clkEn),
    .spiClkPin        (spiClkPin),
    .autoEdge         (r_q.serialIo[gio_pkg::SIO_AUTO_EDGE_BIT]),
    .manualEdgeRising (r_q.serialIo[gio_pkg::SIO_MANUAL_EDGE_BIT]),
    .launchRising     (launchRisingRaw)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d          = r_q;
    r_d.ibaRst   = 1'b0;
    r_d.accept   = 1'b0;
    r_d.discard  = 1'b0;
    r_d.mismatch = 1'b0;
    wrLane       = gio_lane(regAddr);
    rdLane       = gio_lane(regAddr);

    // The strap passes two flip-flops, then is loaded once after release.
    r_d.strapSync = {r_q.strapSync[0], port6RxValidStrapPin};
    if (!r_q.strapDone) begin
      if (r_q.strapCnt == gio_pkg::STRAP_SETTLE) begin
        r_d.inband[gio_pkg::IBA_ENABLE_BIT] = r_q.strapSync[1];
        r_d.strapDone = 1'b1;
      end else begin
        r_d.strapCnt = r_q.strapCnt + 2'h1;
      end
    end

    // Register writes; read-only bits keep their fixed values.
    if (regWrEn) begin
      if (regAddr == gio_pkg::ADDR_SERIAL_IO_CTRL) begin
        r_d.serialIo = gio_merge(r_q.serialIo, regWrData, gio_pkg::SERIAL_IO_WMASK);
      end
      if (regAddr == gio_pkg::ADDR_OUT_CLK_CTRL) begin
        r_d.outClk = gio_merge(r_q.outClk, regWrData, gio_pkg::OUT_CLK_WMASK);
      end
      if (regAddr == gio_pkg::ADDR_PAD_DRIVE) begin
        r_d.padDrive = gio_merge(r_q.padDrive, regWrData, gio_pkg::PAD_DRIVE_WMASK);
      end
      if (gio_in_inband(regAddr)) begin
        // Only the addressed lane changes, so a strap load in other lanes' cycles survives.
        r_d.inband[wrLane*8 +: 8] = gio_merge(r_q.inband[wrLane*8 +: 8], regWrData,
                                              gio_pkg::INBAND_WMASK[wrLane*8 +: 8]);
        // Software wins over a strap load that has not happened yet.
        if (wrLane == 2'h3) begin
          r_d.strapDone = 1'b1;
          // Writing one restarts the in-band engine; the bit is never stored.
          r_d.ibaRst    = regWrData[gio_pkg::IBA_RESET_BIT - 24];
        end
      end
    end

    // Register reads; unmapped addresses return zero.
    if (regRdEn) begin
      if (regAddr == gio_pkg::ADDR_SERIAL_IO_CTRL) begin
        r_d.rdData = r_q.serialIo;
      end else if (regAddr == gio_pkg::ADDR_OUT_CLK_CTRL) begin
        r_d.rdData = r_q.outClk;
      end else if (regAddr == gio_pkg::ADDR_PAD_DRIVE) begin
        r_d.rdData = r_q.padDrive;
      end else if (gio_in_inband(regAddr)) begin
        r_d.rdData = r_q.inband[rdLane*8 +: 8];
      end else begin
        r_d.rdData = 8'h00;
      end
    end

    // In-band frame header check.
    portValid = (r_q.inband[gio_pkg::IBA_PORT_LSB +: 3] <= gio_pkg::PORT_CODE_LAST);
    portOk    = portValid && (ibaFramePort == r_q.inband[gio_pkg::IBA_PORT_LSB +: 3]);
    tpidOk    = (ibaFrameTpid == r_q.inband[gio_pkg::IBA_TPID_LSB +: 16]);
    // Destination check only when matching is enabled.
    macOk     = !r_q.inband[gio_pkg::IBA_MAC_CHECK_BIT] ||
                (ibaFrameDstMac == switchMac);
    if (ibaFrameValid && r_q.inband[gio_pkg::IBA_ENABLE_BIT] && !r_q.ibaRst &&
        portOk && tpidOk) begin
      r_d.accept   = macOk;
      r_d.discard  = !macOk;
      r_d.mismatch = !macOk;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_q           <= '0;
      r_q.serialIo  <= gio_pkg::SERIAL_IO_RESET;
      r_q.outClk    <= gio_pkg::OUT_CLK_RESET;
      r_q.inband    <= gio_pkg::INBAND_RESET;
      r_q.padDrive  <= gio_pkg::PAD_DRIVE_RESET;
    end else if (clkEn) begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign regRdData       = r_q.rdData;
  assign mgmtFrameStart  = frameStartRaw;
  assign sdoLaunchRising = launchRisingRaw;
  assign refClockOutEn   = r_q.outClk[gio_pkg::OCK_ENABLE_BIT];
  assign refClockSel125  = r_q.outClk[gio_pkg::OCK_FREQ_BIT];
  assign ibaFrameAccept  = r_q.accept;
  assign ibaFrameDiscard = r_q.discard;
  assign ibaMacMismatch  = r_q.mismatch;
  assign ibaEngineReset  = r_q.ibaRst;
  assign ibaEnable       = r_q.inband[gio_pkg::IBA_ENABLE_BIT];
  assign ibaRespQueue    = r_q.inband[gio_pkg::IBA_QUEUE_LSB +: 2];
  assign ibaPortSel      = r_q.inband[gio_pkg::IBA_PORT_LSB +: 3];
  assign ibaTpid         = r_q.inband[gio_pkg::IBA_TPID_LSB +: 16];
  assign padHighDrive    = r_q.padDrive[gio_pkg::PAD_HIGH_LSB +: 3];
  assign padLowDrive     = r_q.padDrive[gio_pkg::PAD_LOW_LSB +: 3];

endmodule

// ===== verif/gio_global_io_ctrl_assertions.sv
// Purpose: Concurrent checks on the ports of the global I/O control registers.
// Assumes: One clock domain; read data lags its strobe by one cycle.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module gio_global_io_ctrl_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clkEn,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  // Results
  input wire logic        sdoLaunchRising,
  input wire logic        refClockOutEn,
  input wire logic        refClockSel125,
  input wire logic        ibaFrameValid,
  input wire logic        ibaFrameAccept,
  input wire logic        ibaFrameDiscard,
  input wire logic        ibaMacMismatch,
  input wire logic        ibaEngineReset,
  input wire logic        ibaEnable,
  input wire logic [1:0]  ibaRespQueue,
  input wire logic [2:0]  ibaPortSel,
  input wire logic [15:0] ibaTpid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence rd_s(a); clkEn && regRdEn && regAddr == a; endsequence
  sequence wr_s(a); clkEn && regWrEn && regAddr == a; endsequence
  sequence man_s(v); wr_s(16'h0100) ##0 regWrData[1:0] == v ##1 !regWrEn [*3]; endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  rst_val_a:
    assert property ($fell(reset) |-> ibaTpid == 16'h40FE && ibaPortSel == 3'h5
      && ibaRespQueue == 2'h1 && refClockOutEn && !refClockSel125) else $error("reset value");
  eng_pulse_a:
    assert property (wr_s(16'h0104) ##0 regWrData[5] |=> ibaEngineReset) else $error("no pulse");
  eng_cause_a:
    assert property (ibaEngineReset |-> $past(regWrEn) && $past(regWrData[5])
      && $past(regAddr) == 16'h0104) else $error("stray pulse");
  top_read_a:
    assert property (rd_s(16'h0104) |=> regRdData[5:0] == 6'h00 && regRdData[7] == $past(ibaEnable))
      else $error("read 0x104");
  ctl_read_a:
    assert property (rd_s(16'h0105) |=> regRdData == {$past(ibaRespQueue), 3'h0, $past(ibaPortSel)})
      else $error("read 0x105");
  clk_read_a:
    assert property (rd_s(16'h0103) |=> regRdData[7:5] == 3'h0
      && regRdData[1:0] == {$past(refClockOutEn), $past(refClockSel125)}) else $error("read 0x103");
  tpid_write_a:
    assert property (wr_s(16'h0107) |=> ibaTpid[7:0] == $past(regWrData)) else $error("tpid low");
  frame_cause_a:
    assert property (ibaFrameAccept || ibaFrameDiscard |-> $past(ibaFrameValid) && $past(ibaEnable)
      && !(ibaFrameAccept && ibaFrameDiscard) && ibaMacMismatch == ibaFrameDiscard)
      else $error("frame result");
  man_rise_a:
    assert property (man_s(2'b01) |=> sdoLaunchRising) else $error("manual rising");
  man_fall_a:
    assert property (man_s(2'b00) |=> !sdoLaunchRising) else $error("manual falling");
endmodule

// ===== verif/gio_host_model.sv
// Purpose: Management host model for the two-wire bus and the SPI clock pin.
// Assumes: Pins are asynchronous to the system clock.
// Notes:   Bus clocks stand still low between frames; data idles high on its pull-up.
`timescale 1ns/1ps
module gio_host_model (
  // Bus pins
  output logic mdc,
  output logic mdio,
  output logic sclk
);
  initial begin
    mdc = 1'b0;
    mdio = 1'b1;
    sclk = 1'b0;
  end
  task automatic mgmt_bit(input logic b);
    mdio = b;
    #30 mdc = 1'b1;
    #30 mdc = 1'b0;
  endtask
  // Data bits are ones then zeros, so no false start hides in them.
  task automatic mgmt_frame(input int pre);
    #2;
    for (int i = 0; i < pre; i++) mgmt_bit(1'b1);
    mgmt_bit(1'b0);
    mgmt_bit(1'b1);
    for (int i = 0; i < 30; i++) mgmt_bit(i < 16);
    mdio = 1'b1;
  endtask
  task automatic spi_burst(input int halfNs);
    #2;
    repeat (16) begin
      #(halfNs) sclk = 1'b1;
      #(halfNs) sclk = 1'b0;
    end
  endtask
endmodule

// ===== verif/global_io_control_regs_bench.sv
// Purpose: Self-checking bench of the global I/O control registers.
// Assumes: Strap pin high through reset; clock enable held high.
// Notes:   Expected reads and frame results queue up and a monitor pops them.
`timescale 1ns/1ps
module global_io_control_regs_bench;
  logic        clk_sys, reset, clkEn, regWrEn, regRdEn, mdcPin, mdioPin, spiClkPin;
  logic        mgmtFrameStart, sdoLaunchRising, refClockOutEn, refClockSel125;
  logic        port6RxValidStrapPin, ibaFrameValid, ibaFrameAccept, ibaFrameDiscard;
  logic        ibaMacMismatch, ibaEngineReset, ibaEnable, rdPend, frPend;
  logic [15:0] regAddr, ibaFrameTpid, ibaTpid, tpid;
  logic [7:0]  regWrData, regRdData, rdQ[$];
  logic [47:0] ibaFrameDstMac, switchMac;
  logic [2:0]  ibaFramePort, ibaPortSel, padHighDrive, padLowDrive;
  logic [1:0]  ibaRespQueue, frQ[$];
  int          num_errors, num_checks, starts;
  localparam logic [15:0] ADR [8] = '{16'h0100, 16'h0101, 16'h0103, 16'h0104, 16'h0105,
                                      16'h0106, 16'h0107, 16'h010D};
  localparam logic [7:0] RST [8] = '{8'h42, 8'h00, 8'h02, 8'h80, 8'h45, 8'h40, 8'hFE, 8'h62};
  localparam logic [7:0] MSK [8] = '{8'hFF, 8'h00, 8'h1F, 8'hC0, 8'hC7, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] SREG [5] = '{8'h42, 8'h42, 8'h43, 8'h41, 8'h40};
  localparam int         SHALF [5] = '{15, 50, 50, 50, 15};
  localparam logic [7:0] SEXP [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
  gio_global_io_ctrl dut_u (.clk_sys, .reset, .clkEn, .regAddr, .regWrEn, .regRdEn, .regWrData,
    .regRdData, .mdcPin, .mdioPin, .mgmtFrameStart, .spiClkPin, .sdoLaunchRising, .refClockOutEn,
    .refClockSel125, .port6RxValidStrapPin, .ibaFrameValid, .ibaFrameDstMac, .ibaFrameTpid,
    .ibaFramePort, .switchMac, .ibaFrameAccept, .ibaFrameDiscard, .ibaMacMismatch,
    .ibaEngineReset, .ibaEnable, .ibaRespQueue, .ibaPortSel, .ibaTpid, .padHighDrive,
    .padLowDrive);
  gio_host_model host_u (.mdc(mdcPin), .mdio(mdioPin), .sclk(spiClkPin));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================================
  // Monitor: results appear one cycle after their request.
  // ==========================================================================
  always @(posedge clk_sys) begin
    if (mgmtFrameStart === 1'b1) starts++;
    if (rdPend) check(regRdData, rdQ.pop_front());
    if (frPend) check({ibaFrameAccept, ibaFrameDiscard}, frQ.pop_front());
    rdPend <= regRdEn;
    frPend <= ibaFrameValid;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rdQ.push_back(e);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
  endtask
  task automatic frame(input logic eq, input logic tpOk, input logic [1:0] e);
    @(posedge clk_sys);
    frQ.push_back(e);
    ibaFrameDstMac <= eq ? switchMac : switchMac ^ (48'h1 << ($urandom % 48));
    ibaFrameTpid <= tpOk ? tpid : ~tpid;
    ibaFrameValid <= 1'b1;
    @(posedge clk_sys);
    ibaFrameValid <= 1'b0;
  endtask
  task automatic mgmt(input int pre, input logic [7:0] e);
    int s0;
    s0 = starts;
    host_u.mgmt_frame(pre);
    repeat (40) @(posedge clk_sys);
    check(8'(starts - s0), e);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    {reset, clkEn, port6RxValidStrapPin} = 3'b111;
    {regWrEn, regRdEn, ibaFrameValid} = 3'h0;
    {regAddr, regWrData, ibaFrameTpid, tpid} = 56'h0;
    {ibaFrameDstMac, switchMac} = 96'h0;
    ibaFramePort = 3'h5;
    void'($urandom(32'h7829));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check({1'b0, padHighDrive, 1'b0, padLowDrive}, RST[7]);
    for (int i = 0; i < 8; i++) rd(ADR[i], RST[i]);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(ADR[i], 8'($urandom));
      rd(ADR[i], regWrData & MSK[i]);
    end
    $display("access masks done");
    wr(16'h0104, 8'hE0);
    switchMac <= {16'($urandom), 32'($urandom)};
    tpid = 16'($urandom);
    wr(16'h0106, tpid[15:8]);
    wr(16'h0107, tpid[7:0]);
    wr(16'h0105, 8'h45);
    frame(1'h1, 1'h1, 2'h2);
    frame(1'h0, 1'h1, 2'h1);
    frame(1'h1, 1'h0, 2'h0);
    wr(16'h0104, 8'h80);
    frame(1'h0, 1'h1, 2'h2);
    wr(16'h0105, 8'h46);
    ibaFramePort <= 3'h6;
    frame(1'h1, 1'h1, 2'h0);
    wr(16'h0105, 8'h45);
    ibaFramePort <= 3'h5;
    wr(16'h0104, 8'h00);
    frame(1'h1, 1'h1, 2'h0);
    $display("inband frames done");
    wr(16'h0100, 8'h42);
    mgmt(32, 8'h01);
    mgmt(0, 8'h00);
    wr(16'h0100, 8'h46);
    mgmt(0, 8'h01);
    rd(16'h0100, 8'h46);
    $display("preamble done");
    for (int i = 0; i < 5; i++) begin
      wr(16'h0100, SREG[i]);
      host_u.spi_burst(SHALF[i]);
      @(posedge clk_sys);
      check({7'h00, sdoLaunchRising}, SEXP[i]);
    end
    wr(16'h0100, 8'h42);
    host_u.spi_burst(15);
    repeat (20) @(posedge clk_sys);
    check({7'h00, sdoLaunchRising}, 8'h00);
    $display("spi edge done");
    repeat (3) @(posedge clk_sys);
    conclude;
  end
endmodule
bind gio_global_io_ctrl gio_global_io_ctrl_assertions chk_u (.clk_sys, .reset, .clkEn, .regAddr,
  .regWrEn, .regRdEn, .regWrData, .regRdData, .sdoLaunchRising, .refClockOutEn, .refClockSel125,
  .ibaFrameValid, .ibaFrameAccept, .ibaFrameDiscard, .ibaMacMismatch, .ibaEngineReset,
  .ibaEnable, .ibaRespQueue, .ibaPortSel, .ibaTpid);
